// ### rtl/afe_i2c_pkg.sv
// Shared constants for the two-wire register port and its bus-master controller.
// Assumes one system clock at 25 MHz for both ends.
package afe_i2c_pkg;
   // System clock and serial clock quarter period
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCL_QUARTER_NS = 160;
   localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] QUARTER_LAST = 3'(SCL_QUARTER_CYCLES - 1);

   // Bus address of the device; plain default value
   localparam logic [6:0] SLAVE_ADDR = 7'h28;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Device register file
   localparam int REG_COUNT = 11;
   localparam logic [3:0] REG_LAST = 4'hA;
   localparam logic [3:0] REG_FEATURE = 4'h7;
   localparam logic [3:0] REG_UNLOCK = 4'h8;
   localparam int UNLOCK_BIT = 7;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Controller register map
   localparam logic [2:0] HOST_CMD = 3'h0;
   localparam logic [2:0] HOST_PTR = 3'h1;
   localparam logic [2:0] HOST_WDATA = 3'h2;
   localparam logic [2:0] HOST_RDATA = 3'h3;
   localparam logic [2:0] HOST_STATUS = 3'h4;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_NACK = 1;

   // Controller operations
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_RAND_READ = 2'h1;
   localparam logic [1:0] OP_CUR_READ = 2'h2;

   // Next register pointer, wrapping after the last register
   function automatic logic [3:0] ptr_next(input logic [3:0] p);
      ptr_next = (p >= REG_LAST) ? 4'h0 : 4'(p + 4'h1);
   endfunction : ptr_next
endpackage : afe_i2c_pkg

// ### rtl/afe_i2c_if.sv
// Two-wire link between the bus master and the register port.
// Both ends drive the data line open-drain; the clock comes from the master only.
interface afe_i2c_if;
   logic scl;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;

   // Pulled-up wire: low while either end drives a low
   assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

   modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
   modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface : afe_i2c_if

// ### rtl/afe_i2c_device.sv
// Two-wire slave register port of the front end, with an 11-byte register file.
// Assumes the master makes the serial clock; both lines arrive asynchronously.
//
// Notes on behaviour
// - Transmitter frees data line; receiver acks ninth clock
// - Ack first byte only on own address
// - Ack every write byte after address
// - Read: send, sample ack, continue or stop
// - Master stops after a refused read byte
// - Write: address, pointer, data, each acked
// - Store data on fall after eighth bit
// - Pointer steps after data ack, wraps
// - Master keeps writes below reserved addresses
// - Random read: pointer write, repeated start
// - One data bit per master clock
// - Master ends read with nack, stop
// - Pointer steps after eighth read bit
// - Current read starts at kept pointer
// - Feature register locked after power-up
// - Feature writes need unlock bit set
// - Clearing unlock bit relocks feature register
// - Start and stop framing; idle until start
// - Bytes travel most significant bit first
module afe_i2c_device (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Link
   afe_i2c_if.device link,
   // Register contents seen by the analog side
   output logic [7:0] feature_config,
   output logic [7:0] write_unlock
);
   import afe_i2c_pkg::*;

   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_RX = 5'b00010,
      D_ACK = 5'b00100,
      D_TX = 5'b01000,
      D_TXACK = 5'b10000
   } dev_state_t;

   typedef enum logic [2:0] {
      K_ADDR = 3'b001,
      K_PTR = 3'b010,
      K_DATA = 3'b100
   } byte_kind_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      dev_state_t st;
      byte_kind_t kind;
      logic rd;
      logic mack;
      logic oe;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [3:0] ptr;
      logic [REG_COUNT-1:0][7:0] regs;
   } dev_t;

   localparam dev_t DEV_RST = '{
      scl_s1: 1'b1,
      scl_s2: 1'b1,
      scl_d: 1'b1,
      sda_s1: 1'b1,
      sda_s2: 1'b1,
      sda_d: 1'b1,
      st: D_IDLE,
      kind: K_ADDR,
      rd: 1'b0,
      mack: 1'b0,
      oe: 1'b0,
      bitn: 4'h0,
      sh: 8'h00,
      ptr: 4'h0,
      regs: {REG_COUNT{REG_RESET}}
   };

   dev_t s_ff;
   dev_t nxt_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic feature_open;

   // Register read; addresses past the file read as zero
   function automatic logic [7:0] reg_read(input logic [REG_COUNT-1:0][7:0] r,
                                           input logic [3:0] p);
      reg_read = (p <= REG_LAST) ? r[p] : 8'h00;
   endfunction : reg_read

   // Edges and framing on the synchronised lines
   assign scl_rise = s_ff.scl_s2 & ~s_ff.scl_d;
   assign scl_fall = ~s_ff.scl_s2 & s_ff.scl_d;
   assign start_seen = s_ff.scl_s2 & s_ff.scl_d & s_ff.sda_d & ~s_ff.sda_s2;
   assign stop_seen = s_ff.scl_s2 & s_ff.scl_d & ~s_ff.sda_d & s_ff.sda_s2;
   assign feature_open = s_ff.regs[REG_UNLOCK][UNLOCK_BIT];

   always_comb begin
      nxt_s = s_ff;
      nxt_s.scl_s1 = link.scl;
      nxt_s.scl_s2 = s_ff.scl_s1;
      nxt_s.scl_d = s_ff.scl_s2;
      nxt_s.sda_s1 = link.sda;
      nxt_s.sda_s2 = s_ff.sda_s1;
      nxt_s.sda_d = s_ff.sda_s2;
      if (start_seen) begin
         // A start or repeated start always opens a fresh address byte
         nxt_s.st = D_RX;
         nxt_s.kind = K_ADDR;
         nxt_s.bitn = 4'h0;
         nxt_s.oe = 1'b0;
      end else if (stop_seen) begin
         nxt_s.st = D_IDLE;
         nxt_s.oe = 1'b0;
      end else begin
         case (s_ff.st)
            D_IDLE: begin
               nxt_s.oe = 1'b0;
            end
            D_RX: begin
               if (scl_rise) begin
                  nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s2};
                  nxt_s.bitn = 4'(s_ff.bitn + 4'h1);
               end else if (scl_fall && s_ff.bitn == BYTE_BITS) begin
                  nxt_s.st = D_ACK;
                  nxt_s.oe = 1'b1;
                  case (s_ff.kind)
                     K_ADDR: begin
                        if (s_ff.sh[7:1] != SLAVE_ADDR) begin
                           nxt_s.st = D_IDLE;
                           nxt_s.oe = 1'b0;
                        end else begin
                           nxt_s.rd = s_ff.sh[0];
                        end
                     end
                     K_PTR: begin
                        nxt_s.ptr = s_ff.sh[3:0];
                     end
                     default: begin
                        // Locked feature byte is acked but dropped
                        if (s_ff.ptr <= REG_LAST &&
                            (s_ff.ptr != REG_FEATURE || feature_open)) begin
                           nxt_s.regs[s_ff.ptr] = s_ff.sh;
                        end
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  nxt_s.oe = 1'b0;
                  nxt_s.bitn = 4'h0;
                  if (s_ff.kind == K_ADDR && s_ff.rd) begin
                     // Read continues from the kept pointer
                     nxt_s.st = D_TX;
                     nxt_s.sh = reg_read(s_ff.regs, s_ff.ptr);
                     nxt_s.oe = ~nxt_s.sh[7];
                  end else begin
                     nxt_s.st = D_RX;
                     if (s_ff.kind == K_ADDR) begin
                        nxt_s.kind = K_PTR;
                     end else if (s_ff.kind == K_PTR) begin
                        nxt_s.kind = K_DATA;
                     end else begin
                        nxt_s.ptr = ptr_next(s_ff.ptr);
                     end
                  end
               end
            end
            D_TX: begin
               if (scl_fall) begin
                  nxt_s.bitn = 4'(s_ff.bitn + 4'h1);
                  if (nxt_s.bitn == BYTE_BITS) begin
                     nxt_s.oe = 1'b0;
                     nxt_s.ptr = ptr_next(s_ff.ptr);
                     nxt_s.mack = 1'b0;
                     nxt_s.st = D_TXACK;
                  end else begin
                     nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                     nxt_s.oe = ~nxt_s.sh[7];
                  end
               end
            end
            D_TXACK: begin
               if (scl_rise) begin
                  nxt_s.mack = ~s_ff.sda_s2;
               end else if (scl_fall) begin
                  nxt_s.bitn = 4'h0;
                  if (s_ff.mack) begin
                     nxt_s.st = D_TX;
                     nxt_s.sh = reg_read(s_ff.regs, s_ff.ptr);
                     nxt_s.oe = ~nxt_s.sh[7];
                  end else begin
                     nxt_s.st = D_IDLE;
                  end
               end
            end
            default: begin
               nxt_s.st = D_IDLE;
               nxt_s.oe = 1'b0;
            end
         endcase
      end
   end

   // Power-on reset leaves the unlock bit clear, so the feature register starts locked
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_ff <= DEV_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Open-drain data: only ever pulls low
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = s_ff.oe;
   assign feature_config = s_ff.regs[REG_FEATURE];
   assign write_unlock = s_ff.regs[REG_UNLOCK];
endmodule : afe_i2c_device

// ### rtl/afe_i2c_host.sv
// Bus-master controller that drives the link to the register port.
// Assumes software reaches its registers over a plain strobe port on the same clock.
module afe_i2c_host (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Link
   afe_i2c_if.host link,
   // Software register port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata
);
   import afe_i2c_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BYTE = 4'b0100,
      H_STOP = 4'b1000
   } host_state_t;

   typedef struct packed {
      logic scl_o;
      logic oe;
      logic sda_s1;
      logic sda_s2;
      host_state_t st;
      logic [2:0] cnt;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [2:0] step;
      logic [1:0] op;
      logic is_rx;
      logic ack_miss;
      logic [7:0] ptr;
      logic [7:0] wbyte;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] rbyte;
      logic busy;
      logic nack;
      logic [7:0] bus_rd;
   } host_t;

   localparam host_t HOST_RST = '{st: H_IDLE, scl_o: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                                  default: '0};

   host_t s_ff;
   host_t nxt_s;
   logic tick;
   logic adv;

   assign tick = s_ff.busy && s_ff.cnt == QUARTER_LAST;

   always_comb begin
      nxt_s = s_ff;
      adv = 1'b0;
      nxt_s.sda_s1 = link.sda;
      nxt_s.sda_s2 = s_ff.sda_s1;
      nxt_s.cnt = tick ? 3'h0 : 3'(s_ff.cnt + 3'h1);
      // Software port
      case (addr)
         HOST_PTR: nxt_s.bus_rd = s_ff.ptr;
         HOST_WDATA: nxt_s.bus_rd = s_ff.wbyte;
         HOST_RDATA: nxt_s.bus_rd = s_ff.rbyte;
         HOST_STATUS: nxt_s.bus_rd = {6'h00, s_ff.nack, s_ff.busy};
         default: nxt_s.bus_rd = 8'h00;
      endcase
      if (!rd) begin
         nxt_s.bus_rd = 8'h00;
      end
      if (wr && addr == HOST_PTR) begin
         nxt_s.ptr = wdata;
      end
      if (wr && addr == HOST_WDATA) begin
         nxt_s.wbyte = wdata;
      end
      if (wr && addr == HOST_CMD && !s_ff.busy && wdata[1:0] != 2'h3) begin
         nxt_s.op = wdata[1:0];
         nxt_s.busy = 1'b1;
         nxt_s.nack = 1'b0;
         nxt_s.st = H_START;
         nxt_s.step = 3'h0;
         nxt_s.ph = 2'h0;
         nxt_s.cnt = 3'h0;
      end
      if (tick) begin
         nxt_s.ph = 2'(s_ff.ph + 2'h1);
         case (s_ff.st)
            H_START: begin
               // Release data, raise clock, pull data low, lower clock
               case (s_ff.ph)
                  2'h0: nxt_s.oe = 1'b0;
                  2'h1: nxt_s.scl_o = 1'b1;
                  2'h2: nxt_s.oe = 1'b1;
                  default: begin
                     nxt_s.scl_o = 1'b0;
                     adv = 1'b1;
                  end
               endcase
            end
            H_BYTE: begin
               case (s_ff.ph)
                  2'h0: begin
                     // Ninth clock: free the line after sending, nack after reading
                     if (s_ff.bitn < BYTE_BITS && !s_ff.is_rx) begin
                        nxt_s.oe = ~s_ff.tx[7];
                     end else begin
                        nxt_s.oe = 1'b0;
                     end
                  end
                  2'h1: nxt_s.scl_o = 1'b1;
                  2'h2: begin
                     if (s_ff.bitn < BYTE_BITS) begin
                        nxt_s.rx = {s_ff.rx[6:0], s_ff.sda_s2};
                     end else begin
                        nxt_s.ack_miss = s_ff.sda_s2;
                     end
                  end
                  default: begin
                     nxt_s.scl_o = 1'b0;
                     nxt_s.tx = {s_ff.tx[6:0], 1'b0};
                     nxt_s.bitn = 4'(s_ff.bitn + 4'h1);
                     if (s_ff.bitn == BYTE_BITS) begin
                        if (s_ff.is_rx) begin
                           nxt_s.rbyte = s_ff.rx;
                           adv = 1'b1;
                        end else if (s_ff.ack_miss) begin
                           nxt_s.nack = 1'b1;
                           nxt_s.st = H_STOP;
                        end else begin
                           adv = 1'b1;
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (s_ff.ph)
                  2'h0: nxt_s.oe = 1'b1;
                  2'h1: nxt_s.scl_o = 1'b1;
                  2'h2: nxt_s.oe = 1'b0;
                  default: begin
                     nxt_s.st = H_IDLE;
                     nxt_s.busy = 1'b0;
                  end
               endcase
            end
            default: begin
               nxt_s.st = H_IDLE;
               nxt_s.busy = 1'b0;
            end
         endcase
      end
      if (adv) begin
         nxt_s.step = 3'(s_ff.step + 3'h1);
         nxt_s.bitn = 4'h0;
         nxt_s.is_rx = 1'b0;
         nxt_s.st = H_BYTE;
         // Byte sequence of each operation
         case ({s_ff.op, nxt_s.step})
            {OP_WRITE, 3'h1}, {OP_RAND_READ, 3'h1}: nxt_s.tx = {SLAVE_ADDR, 1'b0};
            {OP_WRITE, 3'h2}, {OP_RAND_READ, 3'h2}: nxt_s.tx = s_ff.ptr;
            {OP_WRITE, 3'h3}: nxt_s.tx = s_ff.wbyte;
            {OP_RAND_READ, 3'h3}: nxt_s.st = H_START;
            {OP_RAND_READ, 3'h4}, {OP_CUR_READ, 3'h1}: nxt_s.tx = {SLAVE_ADDR, 1'b1};
            {OP_RAND_READ, 3'h5}, {OP_CUR_READ, 3'h2}: nxt_s.is_rx = 1'b1;
            default: nxt_s.st = H_STOP;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_ff <= HOST_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign link.scl = s_ff.scl_o;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = s_ff.oe;
   assign rdata = s_ff.bus_rd;
endmodule : afe_i2c_host

// ### verif/afe_i2c_properties.sv
// Concurrent checks on the two-wire link between the bus master and the register port.
// Assumes the master always addresses this port and both ends share one clock.
module afe_i2c_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] bit_cnt_ff;
   logic [2:0] byte_cnt_ff;
   logic read_ff;
   logic frame_ff;

   // Position of the current clock pulse inside its byte and frame
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 3'h0;
         read_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else if (scl && $fell(sda)) begin
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 3'h0;
         frame_ff <= 1'b1;
      end else if (scl && $rose(sda)) begin
         frame_ff <= 1'b0;
      end else if ($rose(scl)) begin
         bit_cnt_ff <= (bit_cnt_ff == 4'h8) ? 4'h0 : bit_cnt_ff + 4'h1;
         if (bit_cnt_ff == 4'h8) begin
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
         end
         if (bit_cnt_ff == 4'h7 && byte_cnt_ff == 3'h0) begin
            read_ff <= sda;
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence s_stop;
      scl && $rose(sda);
   endsequence
   sequence s_ninth_wr;
      $rose(scl) && bit_cnt_ff == 4'h8 && !read_ff;
   endsequence
   sequence s_ninth_rd;
      $rose(scl) && bit_cnt_ff == 4'h8 && byte_cnt_ff != 3'h0 && read_ff;
   endsequence
   sequence s_ninth_addr;
      $rose(scl) && bit_cnt_ff == 4'h8 && byte_cnt_ff == 3'h0;
   endsequence
   // End of a read data bit; the fall after each ninth clock has a zero bit count, so it is left out
   sequence s_read_bit_end;
      $fell(scl) && read_ff && byte_cnt_ff != 3'h0 && bit_cnt_ff != 4'h0;
   endsequence

   a_scl_low_span: assert property ($fell(scl) |-> !scl [*6])
      else $error("serial clock low phase too short");
   a_dev_changes_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("port changed data line while clock high");
   a_addr_acked: assert property (s_ninth_addr |-> !sda)
      else $error("address byte not acknowledged");
   a_write_acked: assert property (s_ninth_wr |-> !sda && !sda_host_oe)
      else $error("written byte not acknowledged by port");
   a_ack_released: assert property (s_ninth_wr |-> ##[9:16] !sda_dev_oe)
      else $error("acknowledge not released after ninth clock");
   a_read_frees: assert property (s_ninth_rd |-> !sda_dev_oe)
      else $error("port holds data line during read acknowledge");
   a_read_nack_stop: assert property (s_ninth_rd |-> sda ##[1:40] s_stop)
      else $error("read not ended by refusal and stop");
   a_host_quiet_read: assert property (s_read_bit_end |-> !sda_host_oe)
      else $error("master drives data line during read bits");
   a_quiet_unframed: assert property (!frame_ff |-> !sda_dev_oe)
      else $error("port drives data line outside a frame");
endmodule : afe_i2c_properties

// ### verif/battery_afe_i2c_register_port_tb_top.sv
// Testbench for the bus master and register port joined by one link.
// A second port on its own link is driven bit by bit to break the framing on purpose.
module battery_afe_i2c_register_port_tb_top import afe_i2c_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock = 1'b0;
   logic resetn;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic [7:0] feature_config;
   logic [7:0] write_unlock;
   logic [7:0] feature_b;
   logic [7:0] unlock_b;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] mon_byte = 8'h00;
   logic [3:0] mon_cnt = 4'h0;
   logic mon_scl = 1'b1;
   logic mon_sda = 1'b1;

   afe_i2c_if link_a ();
   afe_i2c_if link_b ();
   afe_i2c_host u_afe_i2c_host (.clock(clock), .resetn(resetn), .link(link_a.host),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   afe_i2c_device u_afe_i2c_device (.clock(clock), .resetn(resetn), .link(link_a.device),
      .feature_config(feature_config), .write_unlock(write_unlock));
   afe_i2c_device u_afe_i2c_device_b (.clock(clock), .resetn(resetn), .link(link_b.device),
      .feature_config(feature_b), .write_unlock(unlock_b));
   afe_i2c_properties u_afe_i2c_properties (.clock(clock), .resetn(resetn), .scl(link_a.scl),
      .sda(link_a.sda), .sda_host_oe(link_a.sda_host_oe), .sda_dev_oe(link_a.sda_dev_oe));

   always #20 clock = ~clock;

   // Shifts the first byte after each start as seen on the wire
   always @(posedge clock) begin
      mon_scl <= link_a.scl;
      mon_sda <= link_a.sda;
      if (link_a.scl && mon_scl && mon_sda && !link_a.sda) begin
         mon_cnt <= 4'h0;
      end else if (link_a.scl && !mon_scl && mon_cnt < 4'h8) begin
         mon_byte <= {mon_byte[6:0], link_a.sda};
         mon_cnt <= mon_cnt + 4'h1;
      end
   end

   task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check_byte

   task automatic check_flag(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask : check_flag

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      v = rdata;
   endtask : reg_rd

   // One controller command, waited for under a bounded poll
   task automatic run_op(input logic [1:0] op, input logic [3:0] p, input logic [7:0] d,
      output logic [7:0] r);
      logic [7:0] s;
      int n;
      reg_wr(HOST_PTR, {4'h0, p});
      reg_wr(HOST_WDATA, d);
      reg_wr(HOST_CMD, {6'h00, op});
      s = 8'h01;
      n = 0;
      while (s[STATUS_BUSY] !== 1'b0 && n < 4000) begin
         reg_rd(HOST_STATUS, s);
         n++;
      end
      check_flag("busy", 1'b0, s[STATUS_BUSY]);
      check_flag("nack", 1'b0, s[STATUS_NACK]);
      reg_rd(HOST_RDATA, r);
   endtask : run_op

   // One bench-made bit of 320 ns on the second link, with the clock high for 80 ns
   task automatic bb_bit(input logic b, output logic s);
      repeat (5) @(posedge clock);
      link_b.sda_host_oe <= ~b;
      @(posedge clock);
      link_b.scl <= 1'b1;
      repeat (2) @(posedge clock);
      s = link_b.sda;
      link_b.scl <= 1'b0;
   endtask : bb_bit

   task automatic bb_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bb_bit(v[i], s);
      end
      bb_bit(1'b1, s);
      ack = ~s;
   endtask : bb_byte

   // Reads one byte from the second port, then acks it or refuses it
   task automatic bb_read(input logic refuse, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bb_bit(1'b1, s);
         v[i] = s;
      end
      bb_bit(refuse, s);
   endtask : bb_read

   task automatic bb_start();
      @(posedge clock);
      link_b.sda_host_oe <= 1'b1;
      repeat (4) @(posedge clock);
      link_b.scl <= 1'b0;
   endtask : bb_start

   task automatic bb_stop();
      repeat (5) @(posedge clock);
      link_b.sda_host_oe <= 1'b1;
      @(posedge clock);
      link_b.scl <= 1'b1;
      repeat (4) @(posedge clock);
      link_b.sda_host_oe <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : bb_stop

   task automatic t_power_up();
      logic [7:0] r;
      check_flag("scl idle", 1'b1, link_a.scl);
      check_flag("sda idle", 1'b1, link_a.sda);
      check_byte("feature reset", REG_RESET, feature_config);
      check_byte("unlock reset", REG_RESET, write_unlock);
      run_op(OP_RAND_READ, REG_UNLOCK, 8'h00, r);
      check_byte("unlock read", REG_RESET, r);
      $display("test power_up done");
   endtask : t_power_up

   task automatic t_locked();
      logic [7:0] r;
      run_op(OP_WRITE, REG_UNLOCK, 8'h7F, r);
      check_byte("unlock", 8'h7F, write_unlock);
      run_op(OP_WRITE, REG_FEATURE, 8'hA5, r);
      check_byte("locked feature", REG_RESET, feature_config);
      run_op(OP_CUR_READ, 4'h0, 8'h00, r);
      check_byte("pointer after locked", 8'h7F, r);
      check_byte("read address byte", {SLAVE_ADDR, 1'b1}, mon_byte);
      $display("test locked done");
   endtask : t_locked

   task automatic t_unlock();
      logic [7:0] r;
      logic [7:0] key;
      key = 8'(1 << UNLOCK_BIT);
      run_op(OP_WRITE, REG_UNLOCK, key, r);
      check_byte("unlock", key, write_unlock);
      check_byte("write address byte", {SLAVE_ADDR, 1'b0}, mon_byte);
      run_op(OP_WRITE, REG_FEATURE, 8'h5A, r);
      check_byte("feature", 8'h5A, feature_config);
      run_op(OP_RAND_READ, REG_FEATURE, 8'h00, r);
      check_byte("feature read", 8'h5A, r);
      run_op(OP_CUR_READ, 4'h0, 8'h00, r);
      check_byte("next read", key, r);
      run_op(OP_WRITE, REG_UNLOCK, 8'h00, r);
      run_op(OP_WRITE, REG_FEATURE, 8'h33, r);
      check_byte("relocked feature", 8'h5A, feature_config);
      $display("test unlock done");
   endtask : t_unlock

   task automatic t_wrap();
      logic [7:0] r;
      run_op(OP_WRITE, 4'h0, 8'h1E, r);
      run_op(OP_RAND_READ, REG_LAST, 8'h00, r);
      check_byte("last register", REG_RESET, r);
      run_op(OP_CUR_READ, 4'h0, 8'h00, r);
      check_byte("wrapped read", 8'h1E, r);
      $display("test wrap done");
   endtask : t_wrap

   task automatic t_wrong_addr();
      logic a;
      logic [7:0] v;
      bb_start();
      bb_byte({SLAVE_ADDR ^ 7'h01, 1'b0}, a);
      check_flag("foreign address ack", 1'b0, a);
      bb_byte({4'h0, REG_UNLOCK}, a);
      check_flag("unframed ack", 1'b0, a);
      bb_byte(8'hC0, a);
      bb_stop();
      check_byte("unframed store", REG_RESET, unlock_b);
      bb_start();
      bb_byte({SLAVE_ADDR, 1'b0}, a);
      check_flag("own address ack", 1'b1, a);
      bb_byte({4'h0, REG_UNLOCK}, a);
      check_flag("pointer ack", 1'b1, a);
      bb_byte(8'hC0, a);
      check_flag("data ack", 1'b1, a);
      bb_stop();
      check_byte("framed store", 8'hC0, unlock_b);
      check_byte("second feature", REG_RESET, feature_b);
      bb_start();
      bb_byte({SLAVE_ADDR, 1'b0}, a);
      bb_byte({4'h0, REG_FEATURE}, a);
      bb_stop();
      bb_start();
      bb_byte({SLAVE_ADDR, 1'b1}, a);
      check_flag("read address ack", 1'b1, a);
      bb_read(1'b0, v);
      check_byte("first read", REG_RESET, v);
      bb_read(1'b1, v);
      check_byte("continued read", 8'hC0, v);
      bb_stop();
      $display("test wrong_addr done");
   endtask : t_wrong_addr

   initial begin
      resetn = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      link_b.scl = 1'b1;
      link_b.sda_host_o = 1'b0;
      link_b.sda_host_oe = 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_power_up();
      t_locked();
      t_unlock();
      t_wrap();
      t_wrong_addr();
      report_and_stop();
   end

   // Run takes about 7100 cycles; cut it short well beyond that
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      $display("wrong value watchdog expected finish seen timeout");
      report_and_stop();
   end
endmodule : battery_afe_i2c_register_port_tb_top
